// File: logic/ltf_pkg.sv
// Function
// - Send repeating 4384-bit frames: delimiter, control, training bits.
// - Delimiter is sixteen ones then sixteen zeros at each frame start.
// - Delimiter pattern never appears elsewhere within a frame.
// - Update and status fields each span 128 bit times, 16 DME bits.
// - DME clock runs at an eighth of the line rate.
// - Control fields go out most significant bit first, 15 down to 0.
// - Reserved field bits sent as zero and ignored on reception.
// - Update bit 13 requests preset of partner coefficients.
// - Update bit 12 requests initialization of partner coefficients.
// - Update pairs 5:4, 3:2, 1:0 give post, main, pre tap commands.
// - Status bit 15 set when local receiver is ready for data.
// - Status pairs 5:4, 3:2, 1:0 report each tap's update state.
// - Training sequence is 4094 pseudo-random bits then two zeros.
// - Pseudo-random bits go out at the full line rate.
// - Generator loads an 11-bit seed once, then free-runs.
// - Generator polynomial is 1 + x^9 + x^11.
// - Receiver hunts for the delimiter and asserts lock when it recurs one frame later.
// - Receiver presents decoded update and status fields of each frame.
// - On a DME error the outputs keep the last good frame's values.
package ltf_pkg;
    localparam logic [12:0] FRAME_BITS = 13'h1120;
    localparam logic [12:0] FRAME_LAST = 13'h111f;
    localparam logic [12:0] ONES_END = 13'h0010;
    localparam logic [12:0] MARK_END = 13'h0020;
    localparam logic [12:0] MARK_LAST = 13'h001f;
    localparam logic [12:0] CTL_END = 13'h0120;
    localparam logic [12:0] CTL_LAST = 13'h011f;
    localparam logic [12:0] PRBS_END = 13'h111e;
    localparam logic [31:0] MARKER = 32'hffff0000;
    localparam logic [2:0] DME_MID = 3'h4;
    localparam logic [2:0] DME_LAST = 3'h7;
    localparam logic [15:0] UPD_MASK = 16'h303f;
    localparam logic [15:0] STS_MASK = 16'h803f;
    localparam logic [10:0] SEED_RST = 11'h001;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX_UPD = 8'h04;
    localparam logic [7:0] REG_TX_STS = 8'h08;
    localparam logic [7:0] REG_SEED = 8'h0c;
    localparam logic [7:0] REG_RX_UPD = 8'h10;
    localparam logic [7:0] REG_RX_STS = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam int MISS_LIMIT_DEF = 4;
    typedef enum logic [1:0] {
        LTF_HUNT = 2'b00,
        LTF_CHECK = 2'b01,
        LTF_LOCK = 2'b10
    } ltf_state_t;
endpackage

// File: logic/ltf_framer.sv
`timescale 1ns/1ps
`default_nettype none
module ltf_framer #(
    parameter int MISS_LIMIT = ltf_pkg::MISS_LIMIT_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_bit,
    output logic tx_sof,
    input wire logic rx_bit,
    output logic frame_lock,
    output logic [15:0] rx_update,
    output logic [15:0] rx_status,
    output logic rx_new
);
    import ltf_pkg::*;

    logic ctrl_en_r;
    logic [15:0] tx_upd_r;
    logic [15:0] tx_sts_r;
    logic [10:0] seed_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic pslverr_nxt;
    logic apb_wr;
    logic seeded_r;
    logic rx_err_seen_r;
    // Bus answers in the first access cycle
    assign apb_wr = psel && penable && pwrite && pready_r;

    always_comb begin
        prdata_nxt = 32'h0;
        pslverr_nxt = 1'b0;
        case (paddr)
            REG_CTRL: prdata_nxt = {31'h0, ctrl_en_r};
            REG_TX_UPD: prdata_nxt = {16'h0, tx_upd_r};
            REG_TX_STS: prdata_nxt = {16'h0, tx_sts_r};
            REG_SEED: prdata_nxt = {21'h0, seed_r};
            REG_RX_UPD: prdata_nxt = {16'h0, rx_update};
            REG_RX_STS: prdata_nxt = {16'h0, rx_status};
            REG_STAT: prdata_nxt = {29'h0, rx_err_seen_r, seeded_r, frame_lock};
            default: pslverr_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else if (pclken) begin
            pready_r <= psel && !penable;
            if (psel && !penable) begin
                prdata_r <= pwrite ? 32'h0 : prdata_nxt;
                pslverr_r <= pslverr_nxt;
            end
        end
    end

    // Field writes mid-frame are only picked up at the next frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r <= 1'b0;
            tx_upd_r <= 16'h0;
            tx_sts_r <= 16'h0;
            seed_r <= SEED_RST;
        end else if (pclken && apb_wr && !pslverr_r) begin
            case (paddr)
                REG_CTRL: ctrl_en_r <= pwdata[0];
                REG_TX_UPD: tx_upd_r <= pwdata[15:0];
                REG_TX_STS: tx_sts_r <= pwdata[15:0];
                REG_SEED: seed_r <= pwdata[10:0];
                default: ;
            endcase
        end
    end

    // Transmit framer
    logic tx_on_r;
    logic [12:0] tx_pos_r;
    logic [12:0] tx_pos_nxt;
    logic [12:0] tx_fld;
    logic [31:0] tx_sh_r;
    logic tx_bit_r;
    logic tx_bit_nxt;
    logic tx_sof_r;
    logic tx_last_r;
    logic [10:0] lfsr_r;
    logic in_ctl;
    logic in_prbs;
    logic dme_bit;

    always_comb begin
        tx_pos_nxt = (tx_on_r && tx_pos_r != FRAME_LAST) ?
            tx_pos_r + 13'h1 : 13'h0;
        tx_fld = tx_pos_nxt - MARK_END;
        in_ctl = (tx_pos_nxt >= MARK_END) && (tx_pos_nxt < CTL_END);
        in_prbs = (tx_pos_nxt >= CTL_END) && (tx_pos_nxt < PRBS_END);
        // Cell edge always toggles, so runs stay short of the delimiter
        if (tx_fld[2:0] == 3'h0) begin
            dme_bit = !tx_bit_r;
        end else if (tx_fld[2:0] == DME_MID && tx_sh_r[31]) begin
            dme_bit = !tx_bit_r;
        end else begin
            dme_bit = tx_bit_r;
        end
        if (tx_pos_nxt < ONES_END) begin
            tx_bit_nxt = 1'b1;
        end else if (tx_pos_nxt < MARK_END) begin
            tx_bit_nxt = 1'b0;
        end else if (in_ctl) begin
            tx_bit_nxt = dme_bit;
        end else if (in_prbs) begin
            tx_bit_nxt = lfsr_r[10];
        end else begin
            tx_bit_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_on_r <= 1'b0;
            tx_pos_r <= 13'h0;
            tx_bit_r <= 1'b0;
            tx_last_r <= 1'b0;
            tx_sof_r <= 1'b0;
        end else if (pclken) begin
            tx_on_r <= ctrl_en_r;
            tx_last_r <= tx_bit_r;
            if (ctrl_en_r) begin
                tx_pos_r <= tx_pos_nxt;
                tx_bit_r <= tx_bit_nxt;
                tx_sof_r <= (tx_pos_nxt == 13'h0);
            end else begin
                tx_pos_r <= 13'h0;
                tx_bit_r <= 1'b0;
                tx_sof_r <= 1'b0;
            end
        end
    end

    // Fields captured at frame start, reserved bits forced to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sh_r <= 32'h0;
        end else if (pclken && ctrl_en_r) begin
            if (tx_pos_nxt == 13'h0) begin
                tx_sh_r <= {tx_upd_r & UPD_MASK,
                    tx_sts_r & STS_MASK};
            end else if (in_ctl && tx_fld[2:0] == DME_LAST) begin
                tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            end
        end
    end

    // Zero seed would lock the generator, so it is bumped to one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_r <= SEED_RST;
            seeded_r <= 1'b0;
        end else if (pclken && ctrl_en_r) begin
            if (!seeded_r) begin
                lfsr_r <= (seed_r == 11'h0) ? SEED_RST : seed_r;
                seeded_r <= 1'b1;
            end else if (in_prbs) begin
                lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
            end
        end
    end

    assign tx_bit = tx_bit_r;
    assign tx_sof = tx_sof_r;
    // Receive alignment
    ltf_state_t rx_st_r;
    logic [31:0] win_r;
    logic [31:0] win_nxt;
    logic mark_hit;
    logic [12:0] rx_pos_r;
    logic [12:0] rx_pos_nxt;
    logic [12:0] rx_fld;
    logic [2:0] miss_r;
    logic frame_lock_r;

    always_comb begin
        win_nxt = {win_r[30:0], rx_bit};
        mark_hit = (win_nxt == MARKER);
        rx_pos_nxt = (rx_pos_r == FRAME_LAST) ? 13'h0 : rx_pos_r + 13'h1;
        rx_fld = rx_pos_nxt - MARK_END;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_r <= 32'h0;
            rx_st_r <= LTF_HUNT;
            rx_pos_r <= 13'h0;
            miss_r <= 3'h0;
            frame_lock_r <= 1'b0;
        end else if (pclken) begin
            win_r <= win_nxt;
            case (rx_st_r)
                LTF_HUNT: begin
                    miss_r <= 3'h0;
                    if (mark_hit) begin
                        rx_st_r <= LTF_CHECK;
                        rx_pos_r <= MARK_LAST;
                    end
                end
                LTF_CHECK: begin
                    rx_pos_r <= rx_pos_nxt;
                    if (rx_pos_nxt == MARK_LAST) begin
                        rx_st_r <= mark_hit ? LTF_LOCK : LTF_HUNT;
                        frame_lock_r <= mark_hit;
                    end
                end
                LTF_LOCK: begin
                    rx_pos_r <= rx_pos_nxt;
                    if (rx_pos_nxt == MARK_LAST) begin
                        if (mark_hit) begin
                            miss_r <= 3'h0;
                        end else if (32'(miss_r) + 1 >= MISS_LIMIT) begin
                            rx_st_r <= LTF_HUNT;
                            frame_lock_r <= 1'b0;
                            miss_r <= 3'h0;
                        end else begin
                            miss_r <= miss_r + 3'h1;
                        end
                    end
                end
                default: begin
                    rx_st_r <= LTF_HUNT;
                    frame_lock_r <= 1'b0;
                end
            endcase
        end
    end

    assign frame_lock = frame_lock_r;
    // DME decode: edge at every cell start, extra mid edge means one
    logic rx_in_ctl;
    logic dme_err;
    logic rx_ref_r;
    logic rx_err_r;
    logic [31:0] rx_sh_r;
    logic rx_good;
    logic [15:0] rx_upd_r;
    logic [15:0] rx_sts_r;
    logic rx_new_r;

    always_comb begin
        rx_in_ctl = (rx_st_r != LTF_HUNT) && (rx_pos_nxt >= MARK_END) &&
            (rx_pos_nxt < CTL_END);
        if (rx_fld[2:0] == 3'h0) begin
            dme_err = (rx_bit == win_r[0]);
        end else if (rx_fld[2:0] == DME_MID) begin
            dme_err = 1'b0;
        end else begin
            dme_err = (rx_bit != rx_ref_r);
        end
        rx_good = pclken && rx_st_r == LTF_LOCK && rx_pos_nxt == CTL_LAST &&
            !(rx_err_r || dme_err);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ref_r <= 1'b0;
            rx_err_r <= 1'b0;
            rx_err_seen_r <= 1'b0;
            rx_sh_r <= 32'h0;
        end else if (pclken) begin
            if (rx_st_r != LTF_HUNT && rx_pos_nxt == MARK_LAST) begin
                rx_err_r <= 1'b0;
            end else if (rx_in_ctl) begin
                rx_err_r <= rx_err_r || dme_err;
                if (rx_fld[2:0] == 3'h0) begin
                    rx_ref_r <= rx_bit;
                end else if (rx_fld[2:0] == DME_MID) begin
                    rx_ref_r <= rx_bit;
                    rx_sh_r <= {rx_sh_r[30:0], rx_bit != rx_ref_r};
                end
            end
            if (rx_st_r == LTF_LOCK && rx_pos_nxt == CTL_LAST) begin
                rx_err_seen_r <= rx_err_r || dme_err;
            end
        end
    end

    // Outputs change only on an error-free frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_upd_r <= 16'h0;
            rx_sts_r <= 16'h0;
            rx_new_r <= 1'b0;
        end else if (pclken) begin
            rx_new_r <= rx_good;
            if (rx_good) begin
                rx_upd_r <= rx_sh_r[31:16] & UPD_MASK;
                rx_sts_r <= rx_sh_r[15:0] & STS_MASK;
            end
        end
    end

    assign rx_update = rx_upd_r;
    assign rx_status = rx_sts_r;
    assign rx_new = rx_new_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    // Helper: run of equal bits past the delimiter
    logic [4:0] run_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 5'h0;
        end else if (pclken) begin
            if (!ctrl_en_r || tx_pos_nxt < MARK_END) begin
                run_r <= 5'h0;
            end else if (tx_bit_nxt == tx_bit_r && run_r != 5'h1f) begin
                run_r <= run_r + 5'h1;
            end else if (tx_bit_nxt != tx_bit_r) begin
                run_r <= 5'h0;
            end
        end
    end

    property p_sof_pos;
        @(posedge pclk) disable iff (!presetn)
        tx_sof_r |-> tx_pos_r == 13'h0 && tx_bit_r && tx_on_r;
    endproperty
    a_sof_pos: assert property (p_sof_pos) else $error("sof misplaced");

    property p_mark;
        @(posedge pclk) disable iff (!presetn)
        tx_on_r && ctrl_en_r |-> (tx_pos_r < ONES_END) ? tx_bit_r :
            ((tx_pos_r < MARK_END) ? !tx_bit_r : 1'b1);
    endproperty
    a_mark: assert property (p_mark) else $error("bad delimiter bit");

    property p_no_mark;
        @(posedge pclk) disable iff (!presetn)
        run_r < 5'hf;
    endproperty
    a_no_mark: assert property (p_no_mark) else $error("long tx run");

    property p_dme_edge;
        @(posedge pclk) disable iff (!presetn)
        tx_on_r && ctrl_en_r && tx_pos_r >= MARK_END && tx_pos_r < CTL_END &&
            tx_pos_r[2:0] == 3'h0 |-> tx_bit_r != tx_last_r;
    endproperty
    a_dme_edge: assert property (p_dme_edge) else $error("cell edge");

    property p_tail;
        @(posedge pclk) disable iff (!presetn)
        tx_pos_r >= PRBS_END |-> !tx_bit_r;
    endproperty
    a_tail: assert property (p_tail) else $error("tail bits not zero");

    property p_lfsr;
        @(posedge pclk) disable iff (!presetn)
        pclken && ctrl_en_r && seeded_r && in_prbs |=>
            lfsr_r == {$past(lfsr_r[9:0]), $past(lfsr_r[10] ^ lfsr_r[8])};
    endproperty
    a_lfsr: assert property (p_lfsr) else $error("lfsr step wrong");

    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        $rose(frame_lock_r) |-> win_r == MARKER && rx_pos_r == MARK_LAST;
    endproperty
    a_lock: assert property (p_lock) else $error("lock w/o marker");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !rx_good |=> $stable(rx_upd_r) && $stable(rx_sts_r) && !rx_new_r;
    endproperty
    a_hold: assert property (p_hold) else $error("fields changed");

    property p_resv;
        @(posedge pclk) disable iff (!presetn)
        (rx_upd_r & ~UPD_MASK) == 16'h0 && (rx_sts_r & ~STS_MASK) == 16'h0 &&
            (!tx_sof_r || (tx_sh_r & ~{UPD_MASK, STS_MASK}) == 32'h0);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");

    property p_drop;
        @(posedge pclk) disable iff (!presetn)
        $fell(frame_lock_r) |-> rx_st_r == LTF_HUNT && $past(!mark_hit);
    endproperty
    a_drop: assert property (p_drop) else $error("lock lost wrongly");
endmodule
`default_nettype wire

// File: verification/ltf_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ltf_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic [15:0] upd,
    input wire logic [15:0] sts,
    input wire logic bad_dme,
    input wire logic no_mark,
    output logic line_bit,
    output logic sof
);
    import ltf_pkg::*;
    // Arbitrary start value
    localparam logic [10:0] SEED = 11'h3a7;
    logic [12:0] pos_r;
    logic [31:0] fld_r;
    logic err_r;
    logic gap_r;
    logic [10:0] lfsr_r;
    // Level rebuilt from toggle count; no state to drift
    function automatic logic lvl(input logic [12:0] p, input logic [31:0] f,
            input logic e);
        logic l;
        l = 1'b0;
        for (int c = 0; c < 32; c++) begin
            if (13'(32 + 8 * c) <= p && !(e && c == 3)) l = ~l;
            if (f[31 - c] && 13'(36 + 8 * c) <= p) l = ~l;
        end
        return l;
    endfunction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r <= 13'h0000;
            fld_r <= 32'h0000_0000;
            err_r <= 1'b0;
            gap_r <= 1'b0;
        end else if (pclken) begin
            if (pos_r == FRAME_LAST) begin
                pos_r <= 13'h0000;
                // Latched at frame start, so late changes never tear a field
                fld_r <= {upd, sts};
                err_r <= bad_dme;
                gap_r <= no_mark;
            end else begin
                pos_r <= pos_r + 13'h0001;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_r <= SEED;
        end else if (pclken && pos_r >= CTL_END && pos_r < PRBS_END) begin
            lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
        end
    end
    always_comb begin
        if (pos_r < ONES_END) line_bit = ~gap_r;
        else if (pos_r < MARK_END) line_bit = 1'b0;
        else if (pos_r < CTL_END) line_bit = lvl(pos_r, fld_r, err_r);
        else if (pos_r < PRBS_END) line_bit = lfsr_r[10];
        else line_bit = 1'b0;
    end
    assign sof = (pos_r == 13'h0000);
endmodule
`default_nettype wire

// File: verification/ltf_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ltf_pkg::*;
    localparam int MISS = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pclken = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tx_bit, tx_sof, rx_bit, frame_lock, rx_new;
    logic [15:0] rx_update;
    logic [15:0] rx_status;
    logic [15:0] p_upd = 16'h0000;
    logic [15:0] p_sts = 16'h0000;
    logic p_err = 1'b0;
    logic p_gap = 1'b0;
    logic p_sof;
    logic [31:0] rv;
    logic ev;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int lock_cyc = 0;
    logic fb [0:4383];
    always #20 pclk = ~pclk;
    ltf_framer #(.MISS_LIMIT(MISS)) dut_u (.pclk(pclk), .presetn(presetn),
        .pclken(pclken), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_bit(tx_bit), .tx_sof(tx_sof), .rx_bit(rx_bit),
        .frame_lock(frame_lock), .rx_update(rx_update),
        .rx_status(rx_status), .rx_new(rx_new));
    ltf_partner far_u (.pclk(pclk), .presetn(presetn), .pclken(pclken),
        .upd(p_upd), .sts(p_sts), .bad_dme(p_err), .no_mark(p_gap),
        .line_bit(rx_bit), .sof(p_sof));
    always @(posedge pclk) begin
        if (presetn === 1'b1) cyc++;
        if (frame_lock === 1'b1 && lock_cyc == 0) lock_cyc = cyc;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rx_frame(input logic [15:0] u, input logic [15:0] s,
            input logic e, input logic m, output logic seen);
        int n;
        @(posedge pclk);
        p_upd <= u;
        p_sts <= s;
        p_err <= e;
        p_gap <= m;
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (p_sof !== 1'b1 && n < 5000);
        seen = 1'b0;
        repeat (400) begin
            @(posedge pclk);
            #1;
            if (rx_new === 1'b1) seen = 1'b1;
        end
        if (n >= 5000) fails++;
    endtask
    task automatic rx_expect(input logic [15:0] u, input logic [15:0] s,
            input logic e, input logic [15:0] eu, input logic [15:0] es);
        logic seen;
        rx_frame(u, s, e, 1'b0, seen);
        check("rx_new", 32'(seen), 32'(!e));
        check("rx_update", 32'(rx_update), 32'(eu));
        check("rx_status", 32'(rx_status), 32'(es));
    endtask
    task automatic test_regs();
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, rv, ev);
            check("reset_value", rv, (i == 3) ? 32'h1 : 32'h0);
            check("reset_err", 32'(ev), 32'h0);
        end
        apb(1'b0, 8'h1c, 32'h0, rv, ev);
        check("unmapped_err", 32'(ev), 32'h1);
        check("unmapped_data", rv, 32'h0);
    endtask
    task automatic test_tx();
        logic [31:0] got;
        logic [31:0] win;
        int bad;
        int ones;
        int hits;
        int b;
        apb(1'b1, REG_TX_UPD, 32'hf0f5, rv, ev);
        apb(1'b1, REG_TX_STS, 32'h4fe6, rv, ev);
        apb(1'b1, REG_SEED, 32'h5a5, rv, ev);
        apb(1'b1, REG_CTRL, 32'h1, rv, ev);
        b = 0;
        do begin
            @(posedge pclk);
            #1;
            b++;
        end while (tx_sof !== 1'b1 && b < 100);
        for (int i = 0; i < 4384; i++) begin
            fb[i] = tx_bit;
            @(posedge pclk);
            #1;
        end
        check("next_sof", {30'h0, tx_sof, tx_bit}, 32'h3);
        bad = 0;
        for (int i = 0; i < 32; i++) if (fb[i] !== (i < 16)) bad++;
        check("marker", 32'(bad), 32'h0);
        bad = 0;
        for (int c = 0; c < 32; c++) begin
            b = 32 + 8 * c;
            if (fb[b] === fb[b - 1]) bad++;
            for (int o = 1; o < 8; o++) begin
                if (o != 4 && fb[b + o] !== fb[b + o - 1]) bad++;
            end
            got[31 - c] = fb[b + 4] ^ fb[b + 3];
        end
        check("dme_cells", 32'(bad), 32'h0);
        check("tx_fields", got,
            {16'hf0f5 & UPD_MASK, 16'h4fe6 & STS_MASK});
        bad = 0;
        ones = 0;
        win = 32'h0;
        for (int i = 288; i < 4382; i++) begin
            if (fb[i] === 1'b1) ones++;
            if (i < 299) win = {win[30:0], fb[i]};
            if (i >= 299 && fb[i] !== (fb[i - 11] ^ fb[i - 9])) bad++;
        end
        check("prbs_taps", 32'(bad), 32'h0);
        check("prbs_live", 32'(ones > 0), 32'h1);
        check("prbs_seed", win, 32'h5a5);
        check("tail", {30'h0, fb[4382], fb[4383]}, 32'h0);
        hits = 0;
        win = 32'h0;
        for (int i = 0; i < 4384; i++) begin
            win = {win[30:0], fb[i]};
            if (i >= 32 && win === MARKER) hits++;
        end
        check("marker_alias", 32'(hits), 32'h0);
        apb(1'b0, REG_STAT, 32'h0, rv, ev);
        check("seeded", 32'(rv[1]), 32'h1);
        apb(1'b1, REG_CTRL, 32'h0, rv, ev);
        bad = 0;
        repeat (20) begin
            @(posedge pclk);
            #1;
            if (tx_bit !== 1'b0 || tx_sof !== 1'b0) bad++;
        end
        check("tx_off", 32'(bad), 32'h0);
    endtask
    task automatic test_rx();
        logic [1:0] c;
        logic [15:0] u;
        logic [15:0] s;
        check("locked", 32'(frame_lock), 32'h1);
        check("lock_time", 32'(lock_cyc >= 4384 && lock_cyc < 8832),
            32'h1);
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            u = 16'hc0c0 | {2'b00, c, 6'h00, {3{c}}};
            s = 16'h7fc0 | {c[0], 9'h000, {3{c}}};
            rx_expect(u, s, 1'b0, u & UPD_MASK, s & STS_MASK);
        end
        apb(1'b0, REG_RX_UPD, 32'h0, rv, ev);
        check("rx_upd_reg", rv, 32'(16'hf0ff & UPD_MASK));
        apb(1'b0, REG_RX_STS, 32'h0, rv, ev);
        check("rx_sts_reg", rv, 32'(16'hffff & STS_MASK));
    endtask
    task automatic test_err();
        rx_expect(16'h2005, 16'h8012, 1'b0, 16'h2005, 16'h8012);
        rx_expect(16'h1008, 16'h0020, 1'b1, 16'h2005, 16'h8012);
        apb(1'b0, REG_STAT, 32'h0, rv, ev);
        check("stat_dme_err", 32'(rv[2]), 32'h1);
        rx_expect(16'h1008, 16'h0020, 1'b0, 16'h1008, 16'h0020);
    endtask
    task automatic test_loss();
        logic seen;
        rx_frame(16'h0000, 16'h0000, 1'b0, 1'b1, seen);
        check("lock_one_miss", 32'(frame_lock), 32'h1);
        rx_frame(16'h0000, 16'h0000, 1'b0, 1'b1, seen);
        check("lock_lost", 32'(frame_lock), 32'h0);
        rx_frame(16'h0000, 16'h0000, 1'b0, 1'b0, seen);
        rx_frame(16'h0000, 16'h0000, 1'b0, 1'b0, seen);
        check("relock", 32'(frame_lock), 32'h1);
    endtask
    // Both ends frozen; a receiver that kept counting would slip alignment
    task automatic test_freeze();
        @(posedge pclk);
        pclken <= 1'b0;
        repeat (200) @(posedge pclk);
        pclken <= 1'b1;
        check("freeze_lock", 32'(frame_lock), 32'h1);
        rx_expect(16'h1001, 16'h0008, 1'b0, 16'h1001, 16'h0008);
        rx_expect(16'h0006, 16'h8020, 1'b0, 16'h0006, 16'h8020);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_tx();
        test_rx();
        test_err();
        test_loss();
        test_freeze();
        end_of_test();
    end
    // About one and a half times the expected run
    initial begin
        repeat (90000) @(posedge pclk);
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
